// *** rtl/mok_option_irq.sv ***
// Option logic, external and keyscan interrupt front end, reset and clock control.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mok_option_irq #(
	parameter bit keyscan_pin7_irq_option = 1'b1,
	parameter bit keyscan_pin6_irq_option = 1'b1,
	parameter bit keyscan_pin5_irq_option = 1'b1,
	parameter bit keyscan_pin4_irq_option = 1'b1,
	parameter bit keyscan_pin3_irq_option = 1'b0,
	parameter bit keyscan_pin2_irq_option = 1'b0,
	parameter bit keyscan_pin1_irq_option = 1'b1,
	parameter bit keyscan_pin0_irq_option = 1'b1,
	parameter bit keyscan_pullup_option = 1'b1,
	parameter bit pullup_strength_option = 1'b0,
	parameter bit watchdog_enable_option = 1'b1,
	parameter bit halt_instr_enable_option = 1'b1,
	parameter bit irq_level_option = 1'b0
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Device pins.
	input wire logic irq_n_pin,
	input wire logic reset_n_pin,
	input wire logic low_power_reset_n,
	input wire logic [mok_pkg::KEY_W-1:0] keyscan_pin,
	// Core side.
	input wire logic instr_boundary,
	input wire logic cpu_imask,
	input wire logic halt_instr,
	input wire logic wait_instr,
	output logic irq_take,
	output logic core_reset,
	output logic op_clk_en,
	output logic osc_run,
	output logic watchdog_run,
	output logic stop_enter,
	output logic wait_enter,
	output logic core_timer_reset,
	// Pad control.
	output logic [mok_pkg::KEY_W-1:0] keyscan_pullup_en,
	output logic pullup_weak,
	output logic [7:0] port_a_dir,
	output logic [7:0] port_b_dir,
	output logic [7:0] port_c_dir,
	// Register bus.
	input wire logic [mok_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [mok_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [mok_pkg::DATA_W-1:0] reg_rdata,
	// Interrupt output.
	output logic irq_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Fixed option vector.
	localparam logic [mok_pkg::KEY_W-1:0] KEY_OPT = {keyscan_pin7_irq_option,
		keyscan_pin6_irq_option, keyscan_pin5_irq_option, keyscan_pin4_irq_option,
		keyscan_pin3_irq_option, keyscan_pin2_irq_option, keyscan_pin1_irq_option,
		keyscan_pin0_irq_option};

	logic irq_s1_ff, irq_s2_ff, rstn_s1_ff, rstn_s2_ff, lprn_s1_ff, lprn_s2_ff;
	logic [mok_pkg::KEY_W-1:0] key_s1_ff, key_s2_ff, key_d_ff, key_fall;
	logic sys_rst, irq_qual, irq_qual_d_ff, pin_ev, key_ev, pend_ff;
	logic [mok_pkg::LOWCNT_W-1:0] low_cnt_ff;
	logic irq_take_ff, op_clk_en_ff, osc_run_ff, watchdog_run_ff, stop_enter_ff;
	logic wait_enter_ff, core_timer_reset_ff, pullup_weak_ff, core_reset_ff;
	logic [mok_pkg::KEY_W-1:0] keyscan_pullup_en_ff;
	logic [7:0] dir_a_ff, dir_b_ff, dir_c_ff, rdata_ff;
	logic [mok_pkg::ST_W-1:0] stat_ff, mask_ff, stat_set;
	logic [7:0] opt_rd;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_s1_ff <= 1'b1;
			irq_s2_ff <= 1'b1;
			rstn_s1_ff <= 1'b1;
			rstn_s2_ff <= 1'b1;
			lprn_s1_ff <= 1'b1;
			lprn_s2_ff <= 1'b1;
			key_s1_ff <= '1;
			key_s2_ff <= '1;
		end else begin
			irq_s1_ff <= irq_n_pin;
			irq_s2_ff <= irq_s1_ff;
			rstn_s1_ff <= reset_n_pin;
			rstn_s2_ff <= rstn_s1_ff;
			lprn_s1_ff <= low_power_reset_n;
			lprn_s2_ff <= lprn_s1_ff;
			key_s1_ff <= keyscan_pin;
			key_s2_ff <= key_s1_ff;
		end
	end

	// Any reset source resets the logic on sys_rst; only reset and the low-power reset stop the clock divider.
	assign sys_rst = reset | ~rstn_s2_ff | ~lprn_s2_ff;

	always_ff @(posedge ref_clk) begin
		core_reset_ff <= sys_rst;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock divider and oscillator control.
	always_ff @(posedge ref_clk) begin
		if (reset || !lprn_s2_ff) begin
			osc_run_ff <= 1'b0;
			op_clk_en_ff <= 1'b0;
		end else begin
			osc_run_ff <= 1'b1;
			op_clk_en_ff <= ~op_clk_en_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fixed option outputs.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			keyscan_pullup_en_ff <= '0;
			pullup_weak_ff <= 1'b0;
			watchdog_run_ff <= 1'b0;
		end else begin
			keyscan_pullup_en_ff <= keyscan_pullup_option ? KEY_OPT : '0;
			pullup_weak_ff <= pullup_strength_option;
			watchdog_run_ff <= watchdog_enable_option;
		end
	end

	// Stop and wait handling.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stop_enter_ff <= 1'b0;
			wait_enter_ff <= 1'b0;
			core_timer_reset_ff <= 1'b0;
		end else begin
			stop_enter_ff <= halt_instr & halt_instr_enable_option;
			wait_enter_ff <= wait_instr | (halt_instr & ~halt_instr_enable_option);
			core_timer_reset_ff <= halt_instr & ~halt_instr_enable_option;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pin low-time qualification.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			low_cnt_ff <= mok_pkg::LOWCNT_RST;
			irq_qual_d_ff <= 1'b0;
		end else begin
			irq_qual_d_ff <= irq_qual;
			if (irq_s2_ff) begin
				low_cnt_ff <= mok_pkg::LOWCNT_RST;
			end else if (low_cnt_ff != mok_pkg::ILIH_CYC) begin
				low_cnt_ff <= low_cnt_ff + mok_pkg::LOWCNT_ONE;
			end
		end
	end

	assign irq_qual = (low_cnt_ff == mok_pkg::ILIH_CYC);
	// Edge-only mode fires once per low period; level mode keeps requesting.
	assign pin_ev = irq_level_option ? irq_qual : (irq_qual & ~irq_qual_d_ff);

	// Keyscan falling edges per pin, or low levels in level mode.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			key_d_ff <= '1;
		end else begin
			key_d_ff <= key_s2_ff;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < mok_pkg::KEY_W; gi++) begin : g_key
			assign key_fall[gi] = KEY_OPT[gi] & (key_d_ff[gi] & ~key_s2_ff[gi] |
				(irq_level_option & ~key_s2_ff[gi]));
		end
	endgenerate

	assign key_ev = |key_fall;

	////////////////////////////////////////////////////////////////////////////////
	// Pending latch and take at instruction boundary; a new request wins over the clear.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pend_ff <= 1'b0;
			irq_take_ff <= 1'b0;
		end else begin
			irq_take_ff <= instr_boundary & pend_ff & ~cpu_imask;
			if (pin_ev || key_ev) begin
				pend_ff <= 1'b1;
			end else if (instr_boundary && pend_ff && !cpu_imask) begin
				pend_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register bus: direction registers, status, mask and option readback.
	assign stat_set = {halt_instr & ~halt_instr_enable_option,
		instr_boundary & pend_ff & ~cpu_imask, key_ev, pin_ev & ~irq_qual_d_ff};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dir_a_ff <= mok_pkg::DIR_RST;
			dir_b_ff <= mok_pkg::DIR_RST;
			dir_c_ff <= mok_pkg::DIR_RST;
			mask_ff <= mok_pkg::MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				mok_pkg::DIR_A_OFS: begin
					dir_a_ff <= reg_wdata;
				end
				mok_pkg::DIR_B_OFS: begin
					dir_b_ff <= reg_wdata;
				end
				mok_pkg::DIR_C_OFS: begin
					dir_c_ff <= reg_wdata;
				end
				mok_pkg::IRQ_MASK_OFS: begin
					mask_ff <= reg_wdata[mok_pkg::ST_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky status, cleared by writing one; a same-cycle event keeps its bit.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stat_ff <= mok_pkg::ST_RST;
		end else if (reg_wr && reg_addr == mok_pkg::IRQ_STAT_OFS) begin
			stat_ff <= (stat_ff & ~reg_wdata[mok_pkg::ST_W-1:0]) | stat_set;
		end else begin
			stat_ff <= stat_ff | stat_set;
		end
	end

	// Options are read-only; writes to their offset are ignored.
	always_comb begin
		opt_rd = mok_pkg::RD_ZERO;
		opt_rd[mok_pkg::OPT_PULL_BIT] = keyscan_pullup_option;
		opt_rd[mok_pkg::OPT_WEAK_BIT] = pullup_strength_option;
		opt_rd[mok_pkg::OPT_WDOG_BIT] = watchdog_enable_option;
		opt_rd[mok_pkg::OPT_HALT_BIT] = halt_instr_enable_option;
		opt_rd[mok_pkg::OPT_LEVEL_BIT] = irq_level_option;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !reg_rd) begin
			rdata_ff <= mok_pkg::RD_ZERO;
		end else begin
			case (reg_addr)
				mok_pkg::DIR_A_OFS: rdata_ff <= dir_a_ff;
				mok_pkg::DIR_B_OFS: rdata_ff <= dir_b_ff;
				mok_pkg::DIR_C_OFS: rdata_ff <= dir_c_ff;
				mok_pkg::IRQ_STAT_OFS: rdata_ff <= {4'h0, stat_ff};
				mok_pkg::IRQ_MASK_OFS: rdata_ff <= {4'h0, mask_ff};
				mok_pkg::OPTION_OFS: rdata_ff <= opt_rd;
				mok_pkg::PEND_OFS: rdata_ff <= {7'h00, pend_ff};
				default: rdata_ff <= KEY_OPT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign irq_take = irq_take_ff;
	assign core_reset = core_reset_ff;
	assign op_clk_en = op_clk_en_ff;
	assign osc_run = osc_run_ff;
	assign watchdog_run = watchdog_run_ff;
	assign stop_enter = stop_enter_ff;
	assign wait_enter = wait_enter_ff;
	assign core_timer_reset = core_timer_reset_ff;
	assign keyscan_pullup_en = keyscan_pullup_en_ff;
	assign pullup_weak = pullup_weak_ff;
	assign port_a_dir = dir_a_ff;
	assign port_b_dir = dir_b_ff;
	assign port_c_dir = dir_c_ff;
	assign reg_rdata = rdata_ff;
	assign irq_out = |(stat_ff & mask_ff);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	sequence halt_dis_seq;
		!sys_rst && halt_instr && !halt_instr_enable_option;
	endsequence

	sequence take_cond_seq;
		!sys_rst && instr_boundary && pend_ff && !cpu_imask;
	endsequence

	pull_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
		(keyscan_pullup_en_ff & ~KEY_OPT) == '0 &&
		(!keyscan_pullup_option -> keyscan_pullup_en_ff == '0))
		else $error("pull-up on a pin without interrupt option");

	weak_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
		!sys_rst |=> sys_rst || pullup_weak_ff == pullup_strength_option)
		else $error("pull-up strength differs from option");

	wdog_run_a: assert property (@(posedge ref_clk) disable iff (reset)
		watchdog_run_ff |-> watchdog_enable_option)
		else $error("watchdog running with option off");

	stop_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
		stop_enter_ff |-> halt_instr_enable_option && $past(halt_instr))
		else $error("stop entered without enable");

	halt_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
		halt_dis_seq |=> wait_enter_ff && core_timer_reset_ff && !stop_enter_ff)
		else $error("disabled stop did not act as wait with timer reset");

	level_req_a: assert property (@(posedge ref_clk) disable iff (reset)
		!sys_rst && irq_qual && irq_level_option |=> pend_ff)
		else $error("held low level did not keep the request");

	low_time_a: assert property (@(posedge ref_clk) disable iff (reset)
		!sys_rst && $rose(irq_qual) |=> pend_ff ##0 $past(low_cnt_ff) == mok_pkg::ILIH_CYC)
		else $error("qualified low pulse did not set pending latch");

	take_a: assert property (@(posedge ref_clk) disable iff (reset)
		take_cond_seq |=> irq_take_ff)
		else $error("interrupt not taken at boundary");

	no_take_a: assert property (@(posedge ref_clk) disable iff (reset)
		irq_take_ff |-> $past(pend_ff) && !$past(cpu_imask) && $past(instr_boundary))
		else $error("interrupt taken without pending or with mask");

	clk_div_a: assert property (@(posedge ref_clk) disable iff (reset)
		op_clk_en_ff && lprn_s2_ff |=> !op_clk_en_ff ##1 (op_clk_en_ff || !lprn_s2_ff))
		else $error("operating clock enable not oscillator divided by two");

	lp_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
		!lprn_s2_ff |=> !osc_run_ff && !op_clk_en_ff && core_reset_ff)
		else $error("clocks running during low-power reset");

	dir_in_a: assert property (@(posedge ref_clk) disable iff (reset)
		sys_rst |=> dir_a_ff == '0 && dir_b_ff == '0 && dir_c_ff == '0)
		else $error("port line not input after reset");

	key_pend_a: assert property (@(posedge ref_clk) disable iff (reset)
		!sys_rst && key_ev |=> pend_ff)
		else $error("keyscan edge did not set pending latch");
endmodule // mok_option_irq
`default_nettype wire

// *** rtl/mok_pkg.sv ***
// Package with offsets, field positions, reset values and timing counts of the option block.
package mok_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Register bus and keyscan widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int KEY_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [7:0] DIR_A_OFS = 8'h04;
	localparam logic [7:0] DIR_B_OFS = 8'h05;
	localparam logic [7:0] DIR_C_OFS = 8'h06;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h21;
	localparam logic [7:0] OPTION_OFS = 8'h22;
	localparam logic [7:0] PEND_OFS = 8'h23;

	////////////////////////////////////////////////////////////////////////////////
	// Status and mask field positions.
	localparam int ST_PIN_BIT = 0;
	localparam int ST_KEY_BIT = 1;
	localparam int ST_TAKE_BIT = 2;
	localparam int ST_HALTW_BIT = 3;
	localparam int ST_W = 4;

	// Option readback field positions.
	localparam int OPT_PULL_BIT = 0;
	localparam int OPT_WEAK_BIT = 1;
	localparam int OPT_WDOG_BIT = 2;
	localparam int OPT_HALT_BIT = 3;
	localparam int OPT_LEVEL_BIT = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [ST_W-1:0] ST_RST = 4'h0;
	localparam logic [ST_W-1:0] MASK_RST = 4'h0;
	localparam logic [7:0] RD_ZERO = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: minimum low time of the interrupt pin, and clock period.
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_ILIH_PS = 125000;
	localparam int ILIH_CYC_INT = (T_ILIH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOWCNT_W = 8;
	localparam logic [LOWCNT_W-1:0] ILIH_CYC = ILIH_CYC_INT[LOWCNT_W-1:0];
	localparam logic [LOWCNT_W-1:0] LOWCNT_RST = 8'h00;
	localparam logic [LOWCNT_W-1:0] LOWCNT_ONE = 8'h01;
endpackage

// *** testbench/mok_pin_model.sv ***
// Model of the interrupt sources, key matrix and reset pins around the option block.
`timescale 1ns/1ps
`default_nettype none
module mok_pin_model (
	// Clock.
	input wire logic ref_clk,
	// Pins toward the device.
	output var logic irq_n_pin,
	output var logic reset_n_pin,
	output var logic low_power_reset_n,
	output var logic [7:0] keyscan_pin
);
	////////////////////////////////////////////////////////////////////////////////
	// Released lines rest at their pull-up level.
	initial begin
		irq_n_pin = 1'b1;
		reset_n_pin = 1'b1;
		low_power_reset_n = 1'b1;
		keyscan_pin = 8'hFF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holds the interrupt pin low for a number of cycles.
	task automatic press_irq(input int cyc);
		@(posedge ref_clk);
		irq_n_pin <= 1'b0;
		repeat (cyc) @(posedge ref_clk);
		irq_n_pin <= 1'b1;
	endtask

	// Closes one key of the matrix for a number of cycles.
	task automatic press_key(input int idx, input int cyc);
		@(posedge ref_clk);
		keyscan_pin[idx] <= 1'b0;
		repeat (cyc) @(posedge ref_clk);
		keyscan_pin[idx] <= 1'b1;
	endtask

	// Pulls the reset or the low-power reset pin low.
	task automatic hold_reset(input bit lp, input int cyc);
		@(posedge ref_clk);
		if (lp) begin
			low_power_reset_n <= 1'b0;
		end else begin
			reset_n_pin <= 1'b0;
		end
		repeat (cyc) @(posedge ref_clk);
		low_power_reset_n <= 1'b1;
		reset_n_pin <= 1'b1;
	endtask
endmodule // mok_pin_model
`default_nettype wire

// *** testbench/tb_mask_option_irq_keyscan_control.sv ***
// Self-checking testbench of the option and interrupt front-end block.
`timescale 1ns/1ps
`default_nettype none
module tb_mask_option_irq_keyscan_control;
	localparam logic [7:0] KEY_OPT = 8'hF3;
	localparam logic [7:0] OPT_VEC = 8'h0D;
	localparam logic [7:0] ALT_KEY = 8'h04;
	localparam logic [7:0] ALT_VEC = 8'h12;
	logic alt_weak, alt_wdog, alt_osc, alt_take, alt_stop, alt_wait, alt_ctr;
	logic [7:0] alt_pullup_en, alt_rdata;
	logic ref_clk, reset, irq_n_pin, reset_n_pin, low_power_reset_n;
	logic instr_boundary, cpu_imask, halt_instr, wait_instr, reg_wr, reg_rd;
	logic irq_take, core_reset, op_clk_en, osc_run, watchdog_run, irq_out;
	logic stop_enter, wait_enter, core_timer_reset, pullup_weak, prev_clk;
	logic [7:0] keyscan_pin, keyscan_pullup_en, port_a_dir, port_b_dir, port_c_dir;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	////////////////////////////////////////////////////////////////////////////////
	mok_pin_model pins (.ref_clk(ref_clk), .irq_n_pin(irq_n_pin), .reset_n_pin(reset_n_pin),
		.low_power_reset_n(low_power_reset_n), .keyscan_pin(keyscan_pin));

	mok_option_irq #(.keyscan_pin7_irq_option(KEY_OPT[7]), .keyscan_pin6_irq_option(KEY_OPT[6]),
		.keyscan_pin5_irq_option(KEY_OPT[5]), .keyscan_pin4_irq_option(KEY_OPT[4]),
		.keyscan_pin3_irq_option(KEY_OPT[3]), .keyscan_pin2_irq_option(KEY_OPT[2]),
		.keyscan_pin1_irq_option(KEY_OPT[1]), .keyscan_pin0_irq_option(KEY_OPT[0]),
		.keyscan_pullup_option(OPT_VEC[0]), .pullup_strength_option(OPT_VEC[1]),
		.watchdog_enable_option(OPT_VEC[2]), .halt_instr_enable_option(OPT_VEC[3]),
		.irq_level_option(OPT_VEC[4])) dut (
		.ref_clk(ref_clk), .reset(reset), .irq_n_pin(irq_n_pin), .reset_n_pin(reset_n_pin),
		.low_power_reset_n(low_power_reset_n), .keyscan_pin(keyscan_pin),
		.instr_boundary(instr_boundary), .cpu_imask(cpu_imask), .halt_instr(halt_instr),
		.wait_instr(wait_instr), .irq_take(irq_take), .core_reset(core_reset),
		.op_clk_en(op_clk_en), .osc_run(osc_run), .watchdog_run(watchdog_run),
		.stop_enter(stop_enter), .wait_enter(wait_enter), .core_timer_reset(core_timer_reset),
		.keyscan_pullup_en(keyscan_pullup_en), .pullup_weak(pullup_weak),
		.port_a_dir(port_a_dir), .port_b_dir(port_b_dir), .port_c_dir(port_c_dir),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_out(irq_out));

	// Second instance with the opposite option vector and key 2 as the only keyscan interrupt: stop as wait, level mode, no pull-ups.
	mok_option_irq #(.keyscan_pin7_irq_option(ALT_KEY[7]), .keyscan_pin6_irq_option(ALT_KEY[6]),
		.keyscan_pin5_irq_option(ALT_KEY[5]), .keyscan_pin4_irq_option(ALT_KEY[4]),
		.keyscan_pin3_irq_option(ALT_KEY[3]), .keyscan_pin2_irq_option(ALT_KEY[2]),
		.keyscan_pin1_irq_option(ALT_KEY[1]), .keyscan_pin0_irq_option(ALT_KEY[0]),
		.keyscan_pullup_option(ALT_VEC[0]), .pullup_strength_option(ALT_VEC[1]),
		.watchdog_enable_option(ALT_VEC[2]), .halt_instr_enable_option(ALT_VEC[3]),
		.irq_level_option(ALT_VEC[4])) dut_alt (
		.ref_clk(ref_clk), .reset(reset), .irq_n_pin(irq_n_pin), .reset_n_pin(reset_n_pin),
		.low_power_reset_n(low_power_reset_n), .keyscan_pin(keyscan_pin),
		.instr_boundary(instr_boundary), .cpu_imask(cpu_imask), .halt_instr(halt_instr),
		.wait_instr(wait_instr), .irq_take(alt_take), .core_reset(),
		.op_clk_en(), .osc_run(alt_osc), .watchdog_run(alt_wdog),
		.stop_enter(alt_stop), .wait_enter(alt_wait), .core_timer_reset(alt_ctr),
		.keyscan_pullup_en(alt_pullup_en), .pullup_weak(alt_weak),
		.port_a_dir(), .port_b_dir(), .port_c_dir(),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(alt_rdata), .irq_out());

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// Pulses {instr_boundary, halt_instr, wait_instr} and returns after the answer edge.
	task automatic step(input logic [2:0] v);
		@(posedge ref_clk);
		{instr_boundary, halt_instr, wait_instr} <= v;
		@(posedge ref_clk);
		{instr_boundary, halt_instr, wait_instr} <= 3'b000;
		#1;
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		{instr_boundary, cpu_imask, halt_instr, wait_instr, reg_wr, reg_rd} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(port_a_dir | port_b_dir | port_c_dir, mok_pkg::DIR_RST);
		chk(keyscan_pullup_en, KEY_OPT);
		chk({5'h00, pullup_weak, watchdog_run, osc_run}, 8'h03);
		chk(alt_pullup_en, 8'h00);
		chk({5'h00, alt_weak, alt_wdog, alt_osc}, 8'h05);
		prev_clk = op_clk_en;
		@(posedge ref_clk);
		#1;
		chk({7'h00, op_clk_en}, {7'h00, ~prev_clk});
		for (int i = 0; i < 3; i++) begin
			rd(mok_pkg::DIR_A_OFS + 8'(i), mok_pkg::DIR_RST);
		end
		wr(mok_pkg::OPTION_OFS, 8'hFF);
		rd(mok_pkg::OPTION_OFS, OPT_VEC);
		chk(alt_rdata, ALT_VEC);
		rd(8'h3F, KEY_OPT);
		chk(alt_rdata, ALT_KEY);
		wr(mok_pkg::DIR_A_OFS, 8'hA5);
		chk(port_a_dir, 8'hA5);
		fork
			pins.hold_reset(1'b0, 5);
			begin
				repeat (4) @(posedge ref_clk);
				#1;
				chk({7'h00, core_reset}, 8'h01);
			end
		join
		repeat (5) @(posedge ref_clk);
		rd(mok_pkg::DIR_A_OFS, mok_pkg::DIR_RST);
		fork
			pins.hold_reset(1'b1, 8);
			begin
				repeat (6) @(posedge ref_clk);
				#1;
				chk({4'h0, core_reset, osc_run, op_clk_en, watchdog_run}, 8'h08);
			end
		join
		repeat (5) @(posedge ref_clk);
		step(3'b010);
		chk({4'h0, irq_take, stop_enter, wait_enter, core_timer_reset}, 8'h04);
		chk({4'h0, alt_take, alt_stop, alt_wait, alt_ctr}, 8'h03);
		step(3'b001);
		chk({4'h0, irq_take, stop_enter, wait_enter, core_timer_reset}, 8'h02);
		pins.press_irq(20);
		repeat (10) @(posedge ref_clk);
		rd(mok_pkg::PEND_OFS, 8'h00);
		chk(alt_rdata, 8'h00);
		pins.press_key(2, 10);
		repeat (6) @(posedge ref_clk);
		rd(mok_pkg::PEND_OFS, 8'h00);
		chk(alt_rdata, 8'h01);
		fork
			pins.press_irq(80);
			begin
				repeat (45) @(posedge ref_clk);
				rd(mok_pkg::PEND_OFS, 8'h01);
				wr(mok_pkg::IRQ_MASK_OFS, 8'h01);
				chk({7'h00, irq_out}, 8'h01);
				@(posedge ref_clk);
				cpu_imask <= 1'b1;
				step(3'b100);
				chk({7'h00, irq_take}, 8'h00);
				@(posedge ref_clk);
				cpu_imask <= 1'b0;
				step(3'b100);
				chk({7'h00, irq_take}, 8'h01);
				chk({7'h00, alt_take}, 8'h01);
			end
		join
		repeat (4) @(posedge ref_clk);
		rd(mok_pkg::PEND_OFS, 8'h00);
		chk(alt_rdata, 8'h01);
		rd(mok_pkg::IRQ_STAT_OFS, 8'h05);
		wr(mok_pkg::IRQ_STAT_OFS, 8'hFF);
		chk({7'h00, irq_out}, 8'h00);
		rd(mok_pkg::IRQ_STAT_OFS, 8'h00);
		pins.press_key(0, 10);
		repeat (4) @(posedge ref_clk);
		rd(mok_pkg::PEND_OFS, 8'h01);
		rd(mok_pkg::IRQ_STAT_OFS, 8'h02);
		chk({7'h00, irq_out}, 8'h00);
		wr(mok_pkg::IRQ_MASK_OFS, 8'h02);
		chk({7'h00, irq_out}, 8'h01);
		step(3'b100);
		chk({7'h00, irq_take}, 8'h01);
		wr(mok_pkg::IRQ_MASK_OFS, 8'h00);
		chk({7'h00, irq_out}, 8'h00);
		repeat (4) @(posedge ref_clk);
		results();
	end
endmodule // tb_mask_option_irq_keyscan_control
`default_nettype wire
